// ==== tss_map.svh ====
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH
// ----------------------------------------
// Clock and timing constants
// ----------------------------------------
`define TSS_CLK_HZ 50000000
`define TSS_CYC_PER_MS (`TSS_CLK_HZ / 1000)
`define TSS_WARMUP_S 10
`define TSS_WARMUP_MS (`TSS_WARMUP_S * 1000)
`define TSS_STEP_TO_START_MS 100
`define TSS_STEP_DROP_MS 160
`define TSS_RUNON_S 30
`define TSS_RUNON_MS (`TSS_RUNON_S * 1000)
`define TSS_DEBOUNCE_MS 10
// ----------------------------------------
// Input vector bit positions
// ----------------------------------------
`define TSS_IN_HEAT_START 0
`define TSS_IN_HEAT_STOP 1
`define TSS_IN_PLATE_ON 2
`define TSS_IN_PLATE_OFF 3
`define TSS_IN_AIR 4
`define TSS_IN_SAFETY 5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSS_RST_LEVEL 1'b0
`define TSS_RST_CNT 32'h0000_0000
`endif

// ==== tss_pkg.sv ====
package tss_pkg;
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    TSS_OFF  = 7'h01, // All relays off, blower may run on
    TSS_BLOW = 7'h02, // Blower on, waiting for interlocks
    TSS_FIL  = 7'h04, // Control contactor on, filaments heating
    TSS_STEP = 7'h08, // Step contactor closing, inrush limited
    TSS_OVLP = 7'h10, // Step and start both on
    TSS_RUN  = 7'h20, // Start contactor only, full power
    TSS_TRIP = 7'h40  // Interlock shutdown, waiting for closure
  } tss_state_e;
  // Cycle counter type
  typedef logic [31:0] tss_cnt_t;
endpackage

// ==== tss_in_if.sv ====
// Clean front-panel and interlock levels between conditioner and sequencer
interface tss_in_if #(parameter int W = 6);
  logic [W-1:0] level; // Debounced level
  logic [W-1:0] rise;  // One-cycle pulse on debounced rising edge
  modport drv (output level, output rise);
  modport snk (input level, input rise);
endinterface

// ==== tss_debounce.sv ====
`include "tss_map.svh"
module tss_debounce import tss_pkg::*; #(
  parameter int W = 6,
  parameter int STABLE_CYC = `TSS_DEBOUNCE_MS * `TSS_CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] raw,
  tss_in_if.drv clean
);
  // ----------------------------------------
  // Per-input synchroniser and filter
  // ----------------------------------------
  localparam tss_cnt_t STABLE_M1 = tss_cnt_t'(STABLE_CYC - 1);
  genvar g;
  for (g = 0; g < W; g++) begin : g_in
    logic s1; // First stage, read by s2 only
    logic s2; // Synchronised level
    logic lvl; // Accepted level
    logic rse; // Rising edge pulse
    tss_cnt_t cnt; // Cycles the new level has held
    // Two-flop synchroniser against metastability
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        s1 <= `TSS_RST_LEVEL;
        s2 <= `TSS_RST_LEVEL;
      end else begin
        s1 <= raw[g];
        s2 <= s1;
      end
    end
    // Accept a change only after it has held the full window
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        lvl <= `TSS_RST_LEVEL;
        rse <= 1'b0;
        cnt <= `TSS_RST_CNT;
      end else if (s2 == lvl) begin
        // Bounce resets the window
        cnt <= `TSS_RST_CNT;
        rse <= 1'b0;
      end else if (cnt >= STABLE_M1) begin
        lvl <= s2;
        rse <= s2;
        cnt <= `TSS_RST_CNT;
      end else begin
        cnt <= cnt + 32'h0000_0001;
        rse <= 1'b0;
      end
    end
    assign clean.level[g] = lvl;
    assign clean.rise[g] = rse;
  end
endmodule // tss_debounce

// ==== tss_sequencer.sv ====
`include "tss_map.svh"
module tss_sequencer import tss_pkg::*; #(
  parameter int N_SAFE = 1,
  parameter int CYC_PER_MS = `TSS_CYC_PER_MS,
  parameter int WARMUP_MS = `TSS_WARMUP_MS,
  parameter int STEP_MS = `TSS_STEP_TO_START_MS,
  parameter int DROP_MS = `TSS_STEP_DROP_MS,
  parameter int RUNON_MS = `TSS_RUNON_MS,
  parameter int DEBOUNCE_MS = `TSS_DEBOUNCE_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic heater_start_btn,
  input wire logic heater_stop_btn,
  input wire logic plate_on_btn,
  input wire logic plate_off_btn,
  input wire logic air_interlock_closed,
  input wire logic [N_SAFE-1:0] safety_interlock_closed,
  output logic blower_relay_enable,
  output logic control_relay_enable,
  output logic step_relay_enable,
  output logic start_relay_enable,
  output logic filament_warm,
  output logic interlocks_closed,
  output logic [6:0] seq_state
);
  // ----------------------------------------
  // Derived cycle counts
  // ----------------------------------------
  localparam int W = `TSS_IN_SAFETY + N_SAFE;
  localparam tss_cnt_t WARM_CYC = tss_cnt_t'(WARMUP_MS * CYC_PER_MS);
  localparam tss_cnt_t STEP_CYC = tss_cnt_t'(STEP_MS * CYC_PER_MS);
  localparam tss_cnt_t DROP_CYC = tss_cnt_t'(DROP_MS * CYC_PER_MS);
  localparam tss_cnt_t RUNON_CYC = tss_cnt_t'(RUNON_MS * CYC_PER_MS);
  localparam tss_cnt_t ONE = 32'h0000_0001;

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  tss_in_if #(.W(W)) cin ();
  tss_debounce #(.W(W), .STABLE_CYC(DEBOUNCE_MS * CYC_PER_MS)) u_deb (
    .core_clk(core_clk),
    .rst(rst),
    .raw({safety_interlock_closed, air_interlock_closed, plate_off_btn,
          plate_on_btn, heater_stop_btn, heater_start_btn}),
    .clean(cin.drv)
  );

  // Debounced press pulses and interlock summary
  logic start_p; // Heater start press
  logic stop_p; // Heater stop press
  logic pon_p; // Plate on press
  logic poff_p; // Plate off press
  logic ilk_ok; // Air and every safety interlock closed
  assign start_p = cin.rise[`TSS_IN_HEAT_START];
  assign stop_p = cin.rise[`TSS_IN_HEAT_STOP];
  assign pon_p = cin.rise[`TSS_IN_PLATE_ON];
  assign poff_p = cin.rise[`TSS_IN_PLATE_OFF];
  assign ilk_ok = &cin.level[W-1:`TSS_IN_AIR];

  // ----------------------------------------
  // State and timers
  // ----------------------------------------
  tss_state_e state; // Current state
  tss_state_e next_state; // Next state
  tss_cnt_t seq_cnt; // Cycles spent in step / overlap state
  tss_cnt_t warm_cnt; // Cycles the filaments have been powered
  tss_cnt_t runon_cnt; // Cycles of blower run-on so far
  logic warm; // Warm-up delay has elapsed
  logic plate_req; // Plate on pressed, not yet served or cancelled
  logic runon_act; // Blower run-on in progress
  logic runon_go; // Start a run-on this cycle
  logic in_start; // A start sequence is still in progress

  assign warm = (warm_cnt >= WARM_CYC);
  // Filament warm-up and plate ramp count as the start sequence
  assign in_start = ((state == TSS_FIL) && !warm) || (state == TSS_STEP) || (state == TSS_OVLP);
  // Run-on follows a stop outside TSS_OFF and TSS_TRIP, or a trip whose interlocks closed again with no stop
  assign runon_go = (stop_p && (state != TSS_OFF) && (state != TSS_TRIP))
                 || ((state == TSS_TRIP) && ilk_ok && !stop_p);

  // Next-state decode; stop beats interlocks beats operator requests
  always_comb begin
    next_state = state;
    unique case (state)
      TSS_OFF: begin
        if (start_p && !stop_p) begin
          next_state = TSS_BLOW;
        end
      end
      TSS_BLOW: begin
        if (stop_p) begin
          next_state = TSS_OFF;
        end else if (ilk_ok) begin
          next_state = TSS_FIL;
        end
      end
      TSS_FIL: begin
        if (stop_p) begin
          next_state = TSS_OFF;
        end else if (!ilk_ok) begin
          // Abort while heating, trip once warm
          next_state = warm ? TSS_TRIP : TSS_OFF;
        end else if (warm && plate_req) begin
          next_state = TSS_STEP;
        end
      end
      TSS_STEP: begin
        if (stop_p) begin
          next_state = TSS_OFF;
        end else if (!ilk_ok) begin
          next_state = TSS_OFF;
        end else if (poff_p) begin
          next_state = TSS_FIL;
        end else if (seq_cnt == STEP_CYC - ONE) begin
          next_state = TSS_OVLP;
        end
      end
      TSS_OVLP: begin
        if (stop_p) begin
          next_state = TSS_OFF;
        end else if (!ilk_ok) begin
          next_state = TSS_OFF;
        end else if (poff_p) begin
          next_state = TSS_FIL;
        end else if (seq_cnt == DROP_CYC - ONE) begin
          next_state = TSS_RUN;
        end
      end
      TSS_RUN: begin
        if (stop_p) begin
          next_state = TSS_OFF;
        end else if (!ilk_ok) begin
          next_state = TSS_TRIP;
        end else if (poff_p) begin
          next_state = TSS_FIL;
        end
      end
      TSS_TRIP: begin
        // Cooling restarts; operator must press start again
        if (ilk_ok || stop_p) begin
          next_state = TSS_OFF;
        end else if (start_p) begin
          next_state = TSS_BLOW;
        end
      end
      default: begin
        next_state = TSS_OFF; // Illegal code falls safe
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= TSS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Step / overlap interval timer, cleared on every state change
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq_cnt <= `TSS_RST_CNT;
    end else if (next_state != state) begin
      seq_cnt <= `TSS_RST_CNT;
    end else begin
      seq_cnt <= seq_cnt + ONE;
    end
  end

  // Warm-up timer runs while the control contactor is on, saturates
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      warm_cnt <= `TSS_RST_CNT;
    end else if (!control_relay_enable) begin
      warm_cnt <= `TSS_RST_CNT;
    end else if (!warm) begin
      warm_cnt <= warm_cnt + ONE;
    end
  end

  // Plate request latch; a press beats plate off, but only while the next state is TSS_FIL
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      plate_req <= 1'b0;
    end else if (pon_p && (next_state == TSS_FIL)) begin
      plate_req <= 1'b1;
    end else if (poff_p || (next_state != TSS_FIL)) begin
      plate_req <= 1'b0;
    end
  end

  // Blower run-on timer; a fresh start takes the blower over
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      runon_act <= 1'b0;
      runon_cnt <= `TSS_RST_CNT;
    end else if (runon_go) begin
      runon_act <= 1'b1;
      runon_cnt <= `TSS_RST_CNT;
    end else if (next_state != TSS_OFF) begin
      runon_act <= 1'b0;
      runon_cnt <= `TSS_RST_CNT;
    end else if (runon_act) begin
      // Ends after the full period, never sooner
      runon_act <= (runon_cnt != RUNON_CYC - ONE);
      runon_cnt <= runon_cnt + ONE;
    end
  end

  // ----------------------------------------
  // Relay drives, registered from next state
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blower_relay_enable <= 1'b0;
      control_relay_enable <= 1'b0;
      step_relay_enable <= 1'b0;
      start_relay_enable <= 1'b0;
    end else begin
      // Run-on drive drops on the last counted cycle, so the blower stands exactly the period
      blower_relay_enable <= ((next_state != TSS_OFF) && (next_state != TSS_TRIP))
                          || runon_go
                          || ((next_state == TSS_OFF) && runon_act && (runon_cnt != RUNON_CYC - ONE));
      control_relay_enable <= (next_state == TSS_FIL) || (next_state == TSS_STEP)
                           || (next_state == TSS_OVLP) || (next_state == TSS_RUN);
      step_relay_enable <= (next_state == TSS_STEP) || (next_state == TSS_OVLP);
      start_relay_enable <= (next_state == TSS_OVLP) || (next_state == TSS_RUN);
    end
  end

  // Status reflects internal state
  assign filament_warm = warm;
  assign interlocks_closed = ilk_ok;
  assign seq_state = state;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  tss_cnt_t step_on_cnt; // Cycles the step relay has been on
  tss_cnt_t ovl_cnt; // Cycles step and start have overlapped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_on_cnt <= `TSS_RST_CNT;
      ovl_cnt <= `TSS_RST_CNT;
    end else begin
      step_on_cnt <= step_relay_enable ? step_on_cnt + ONE : `TSS_RST_CNT;
      ovl_cnt <= (step_relay_enable && start_relay_enable) ? ovl_cnt + ONE : `TSS_RST_CNT;
    end
  end

  sequence s_trip_seen;
    (state == TSS_RUN) && !ilk_ok && !stop_p;
  endsequence
  sequence s_all_off;
    !control_relay_enable && !step_relay_enable && !start_relay_enable && !blower_relay_enable;
  endsequence

  property p_start_blower;
    @(posedge core_clk) disable iff (rst)
      (state == TSS_OFF) && start_p && !stop_p |=> blower_relay_enable && (state == TSS_BLOW);
  endproperty
  a_start_blower: assert property (p_start_blower) else $error("Blower not enabled on start");

  property p_ctrl_ilk;
    @(posedge core_clk) disable iff (rst)
      $rose(control_relay_enable) |-> $past(ilk_ok) && blower_relay_enable;
  endproperty
  a_ctrl_ilk: assert property (p_ctrl_ilk) else $error("Control relay without interlocks");

  property p_plate_warm;
    @(posedge core_clk) disable iff (rst)
      $rose(step_relay_enable) |-> $past(warm) && $past(plate_req) && $past(warm_cnt) >= WARM_CYC;
  endproperty
  a_plate_warm: assert property (p_plate_warm) else $error("Plate started before warm-up");

  property p_step_start;
    @(posedge core_clk) disable iff (rst)
      $rose(start_relay_enable) |-> step_relay_enable && (step_on_cnt == STEP_CYC);
  endproperty
  a_step_start: assert property (p_step_start) else $error("Step to start gap wrong");

  property p_step_drop;
    @(posedge core_clk) disable iff (rst)
      $fell(step_relay_enable) && start_relay_enable |-> ovl_cnt == DROP_CYC;
  endproperty
  a_step_drop: assert property (p_step_drop) else $error("Step drop time wrong");

  property p_ctrl_first;
    @(posedge core_clk) disable iff (rst)
      (step_relay_enable || start_relay_enable) |-> control_relay_enable && $past(control_relay_enable);
  endproperty
  a_ctrl_first: assert property (p_ctrl_first) else $error("Plate relay without control");

  property p_abort;
    @(posedge core_clk) disable iff (rst)
      in_start && !ilk_ok |=> (state == TSS_OFF) && !control_relay_enable ##1 (state == TSS_OFF);
  endproperty
  a_abort: assert property (p_abort) else $error("Start sequence not aborted");

  property p_trip;
    @(posedge core_clk) disable iff (rst)
      s_trip_seen |=> s_all_off;
  endproperty
  a_trip: assert property (p_trip) else $error("Supplies not dropped on trip");

  property p_cool;
    @(posedge core_clk) disable iff (rst)
      (state == TSS_TRIP) && ilk_ok && !stop_p |=> blower_relay_enable && !control_relay_enable
        && !step_relay_enable && !start_relay_enable;
  endproperty
  a_cool: assert property (p_cool) else $error("Cooling restart wrong");

  property p_plate_off;
    @(posedge core_clk) disable iff (rst)
      (state == TSS_RUN) && poff_p && ilk_ok && !stop_p |=> !step_relay_enable && !start_relay_enable
        && control_relay_enable;
  endproperty
  a_plate_off: assert property (p_plate_off) else $error("Plate off failed");

  property p_stop;
    @(posedge core_clk) disable iff (rst)
      stop_p && (state != TSS_OFF) |=> !control_relay_enable && !step_relay_enable && !start_relay_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("Heater stop left a supply on");

  property p_runon;
    @(posedge core_clk) disable iff (rst)
      $fell(blower_relay_enable) && $past(state == TSS_OFF) |-> $past(runon_cnt) == RUNON_CYC - ONE;
  endproperty
  a_runon: assert property (p_runon) else $error("Blower run-on length wrong");
endmodule // tss_sequencer

// ==== tss_air_model.sv ====
// ----------------------------------------
// Air pressure switch beside the blower
// ----------------------------------------
module tss_air_model import tss_pkg::*; #(
  parameter int AIR_DLY = 40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic blower_relay_enable,
  output logic air_interlock_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  tss_cnt_t press_cnt; // Pressure build-up in cycles

  // Pressure rises while the blower runs and decays at the same rate, one count per cycle, after it stops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      press_cnt <= '0;
    end else if (blower_relay_enable && press_cnt < AIR_DLY) begin
      press_cnt <= press_cnt + 32'h1;
    end else if (!blower_relay_enable && press_cnt > 0) begin
      press_cnt <= press_cnt - 32'h1;
    end
  end

  // Hysteresis: closes at full pressure, opens only once pressure is gone,
  // so a short blower gap does not open the switch at once
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      air_interlock_closed <= 1'b0;
    end else if (press_cnt == AIR_DLY) begin
      air_interlock_closed <= 1'b1;
    end else if (press_cnt == 0) begin
      air_interlock_closed <= 1'b0;
    end
  end
endmodule // tss_air_model

// ==== tb.sv ====
`include "tss_map.svh"
module tb import tss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Scaled timing
  // ----------------------------------------
  localparam int CPM = 10; // Short millisecond keeps the run brief
  localparam int WARM_MS = 5;
  localparam int RUN_MS = 5;
  localparam int WARM_CYC = WARM_MS * CPM;
  localparam int RUN_CYC = RUN_MS * CPM;
  localparam int STEP_CYC = `TSS_STEP_TO_START_MS * CPM;
  localparam int DROP_CYC = `TSS_STEP_DROP_MS * CPM;
  localparam int LIMIT = 30000; // Cycle ceiling for a hang
  logic core_clk = 1'b0;
  logic rst;
  logic [3:0] btn; // Start, stop, plate on, plate off
  logic air_interlock_closed;
  logic [1:0] safety_interlock_closed;
  logic blower_relay_enable, control_relay_enable, step_relay_enable, start_relay_enable;
  logic filament_warm, interlocks_closed;
  logic [6:0] seq_state;
  logic [3:0] relays; // Blower, control, step, start
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int ctrl_age = 0; // Cycles since control relay came on
  assign relays = {blower_relay_enable, control_relay_enable, step_relay_enable, start_relay_enable};

  tss_sequencer #(.N_SAFE(2), .CYC_PER_MS(CPM), .WARMUP_MS(WARM_MS), .STEP_MS(`TSS_STEP_TO_START_MS),
    .DROP_MS(`TSS_STEP_DROP_MS), .RUNON_MS(RUN_MS), .DEBOUNCE_MS(1)) dut_u (
    .core_clk(core_clk), .rst(rst), .heater_start_btn(btn[0]), .heater_stop_btn(btn[1]),
    .plate_on_btn(btn[2]), .plate_off_btn(btn[3]), .air_interlock_closed(air_interlock_closed),
    .safety_interlock_closed(safety_interlock_closed), .blower_relay_enable(blower_relay_enable),
    .control_relay_enable(control_relay_enable), .step_relay_enable(step_relay_enable),
    .start_relay_enable(start_relay_enable), .filament_warm(filament_warm),
    .interlocks_closed(interlocks_closed), .seq_state(seq_state));
  tss_air_model #(.AIR_DLY(40)) air_u (.core_clk(core_clk), .rst(rst),
    .blower_relay_enable(blower_relay_enable), .air_interlock_closed(air_interlock_closed));

  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Warm-up age and hang guard
  always @(posedge core_clk) begin
    ctrl_age <= (control_relay_enable === 1'b1) ? ctrl_age + 1 : 0;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      end_sim();
    end
  end
  // Verdict and end of run
  task automatic end_sim();
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Inputs always change one nanosecond after the edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Relay pattern expected in each state
  function automatic logic [3:0] exp_relays(input logic [6:0] st);
    case (st)
      TSS_BLOW: return 4'h8;
      TSS_FIL: return 4'hC;
      TSS_STEP: return 4'hE;
      TSS_OVLP: return 4'hF;
      TSS_RUN: return 4'hD;
      default: return 4'h0;
    endcase
  endfunction
  // Bounded wait for a state; n returns cycles spent
  task automatic wait_state(input logic [6:0] st, output int n);
    n = 0;
    while (seq_state !== st && n < 5000) begin
      step(1);
      n++;
    end
    check("seq_state", seq_state, st);
  endtask
  task automatic reach(input logic [6:0] st, output int n);
    wait_state(st, n);
    check("relays", relays, exp_relays(st));
  endtask
  // Random hold long enough to pass the debounce window
  task automatic press(input int idx);
    btn[idx] = 1'b1;
    step($urandom_range(15, 30));
    btn[idx] = 1'b0;
    step(20);
  endtask
  // High voltage on, with exact step and overlap timing
  task automatic plate_up();
    int n;
    btn[2] = 1'b1;
    reach(TSS_STEP, n);
    check("warmup", ctrl_age >= WARM_CYC, 1'b1);
    check("control_on", control_relay_enable, 1'b1);
    check("warm_flag", filament_warm, 1'b1);
    check("ilk_closed", interlocks_closed, 1'b1);
    btn[2] = 1'b0;
    reach(TSS_OVLP, n);
    check("step_to_start", n, STEP_CYC);
    reach(TSS_RUN, n);
    check("overlap", n, DROP_CYC);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    btn = 4'h0;
    safety_interlock_closed = 2'h3;
    rst = 1'b1;
    void'($urandom(32'hE67C));
    step(10);
    check("reset_relays", relays, 4'h0);
    check("reset_state", seq_state, TSS_OFF);
    rst = 1'b0;
    // Short random blips on start must be ignored
    repeat (6) begin
      btn[0] = 1'b1;
      step($urandom_range(1, 7));
      btn[0] = 1'b0;
      step(12);
      check("glitch", relays, 4'h0);
    end
    // Start with one safety loop open: blower only
    safety_interlock_closed[$urandom_range(0, 1)] = 1'b0;
    press(0);
    reach(TSS_BLOW, n);
    step(100);
    check("ctrl_held", relays, 4'h8);
    check("ilk_open", interlocks_closed, 1'b0);
    safety_interlock_closed = 2'h3;
    reach(TSS_FIL, n);
    check("not_warm", filament_warm, 1'b0);
    plate_up();
    // Plate off keeps filaments, then plate on again
    press(3);
    reach(TSS_FIL, n);
    plate_up();
    // Stop from full power, blower runs on
    btn[1] = 1'b1;
    wait_state(TSS_OFF, n);
    check("stop_relays", relays, 4'h8);
    n = 0;
    while (blower_relay_enable === 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
    check("runon", n, RUN_CYC);
    btn[1] = 1'b0;
    step(20);
    // Loop opens before warm-up ends: abort to off
    press(0);
    reach(TSS_FIL, n);
    safety_interlock_closed[0] = 1'b0;
    reach(TSS_OFF, n);
    safety_interlock_closed = 2'h3;
    step(100);
    check("abort_stays", relays, 4'h0);
    // Loop opens at full power: trip, then prompt closure
    press(0);
    reach(TSS_FIL, n);
    plate_up();
    safety_interlock_closed[1] = 1'b0;
    reach(TSS_TRIP, n);
    check("trip_fast", n <= 20, 1'b1);
    safety_interlock_closed = 2'h3;
    wait_state(TSS_OFF, n);
    check("cool_blower", relays, 4'h8);
    step(200);
    check("no_restart", relays, 4'h0);
    check("off_after", seq_state, TSS_OFF);
    end_sim();
  end
endmodule // tb
